// ==== rtl/dmc_core.sv ====
// Multiplier, product shifter, central ALU, sum register and status bits
//
// Notes on behaviour
// RULE1: Product shift: left one, left four, right six
// RULE2: Left four suits thirteen-bit immediate multiplies
// RULE3: Immediate multiply yields a product every two cycles
// RULE4: Operand load also loads/adds/moves/subtracts old product
// RULE5: Multiply-sum takes both operands every cycle
// RULE6: Moving multiply-sum shifts sample to next address
// RULE7: Unsigned multiply treats both operands as unsigned
// RULE8: Square ops feed one value to both inputs
// RULE9: Full 32-bit product lands in product register
// RULE10: Product reads always pass the product shifter
// RULE11: Times zero clears, times one copies, high loadable
// RULE12: ALU takes sum register plus shifter input
// RULE13: Left justify shifts sum register left
// RULE14: Operand-shifted ops use four operand bits
// RULE15: Operand bit test uses four bits, keeps sum
// RULE16: Saturation clamps to extreme values, sets wrap flag
// RULE17: Without saturation wrap freely; logic never wraps
// RULE18: Wrap, zero and computed jump conditions provided
// RULE19: Arithmetic and shifts update carry; others keep it
// RULE20: Carry add and borrow subtract use old carry
// RULE21: High-word add only sets, subtract only clears carry
// RULE22: Carry resets to one, settable, loadable, a condition
// RULE23: Select codes 00 none, 01, 10, 11 as given
// RULE24: Input shifter left 0 to 16, sign select
// RULE25: Wrap flag sticky until reset, branch or load
// RULE26: Multiply completes within one cycle; immediate multiply here takes two cycles
`timescale 1ns/1ps
module dmc_core (
   input  wire logic                 mclk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 op_valid_i,
   input  wire dmc_pkg::dmc_op_type  op_code_i,
   input  wire logic [15:0]          data_read_bus_i,
   input  wire logic [15:0]          program_read_bus_i,
   input  wire logic [4:0]           shift_count_i,
   input  wire dmc_pkg::dmc_sts_type status_sel_i,
   output logic                      op_ready_o,
   output logic [31:0]               sum_register_o,
   output logic [31:0]               product_holding_reg_o,
   output logic [15:0]               multiplier_operand_reg_o,
   output logic [31:0]               product_shifter_o,
   output logic [1:0]                product_shift_select_o,
   output logic                      carry_o,
   output logic                      arith_wrap_flag_o,
   output logic                      saturation_enable_o,
   output logic                      sign_extend_select_o,
   output logic                      test_flag_o,
   output logic                      zero_result_cond_o,
   output logic [15:0]               computed_jump_o,
   output logic                      data_move_o
);
   import dmc_pkg::*;

   typedef struct packed {
      logic [31:0] sum_reg;
      logic [31:0] prod_reg;
      logic [15:0] opnd_reg;
      logic [12:0] imm;
      logic        busy;
      logic        carry;
      logic        wrap;
      logic        sat_en;
      logic        sx_sel;
      logic        tc;
      logic [1:0]  ps_sel;
      logic        move;
   } dmc_state_type;

   localparam dmc_state_type ST_RST = '{
      sum_reg: 32'h0, prod_reg: 32'h0, opnd_reg: 16'h0, imm: 13'h0,
      busy: 1'b0, carry: RST_CARRY, wrap: RST_WRAP, sat_en: RST_SAT,
      sx_sel: RST_SX, tc: 1'b0, ps_sel: RST_PS, move: 1'b0};

   dmc_state_type st_ff;
   dmc_state_type nxt_st;

   logic [1:0]         rsync_ff;
   logic               rst_n;
   logic               fire;
   logic [31:0]        ps_out;
   logic [31:0]        ext_data;
   logic [31:0]        is_imm;
   logic [31:0]        is_opnd;
   logic [15:0]        mul_a;
   logic [15:0]        mul_b;
   logic signed [31:0] prod_s;
   logic [31:0]        prod_u;
   logic               sq_sel;
   logic               ms_sel;
   logic               operand_indexed_test_sel;
   dmc_alu_type        alu_k;
   dmc_cy_type         cy_k;
   logic [31:0]        alu_b;
   logic [31:0]        b_eff;
   logic               cin;
   logic [32:0]        sum33;
   logic               wrapped;
   logic [31:0]        arith;

   // Reset release through two flops
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsync_ff <= 2'h0;
      end else begin
         rsync_ff <= {rsync_ff[0], 1'b1};
      end
   end
   assign rst_n = rsync_ff[1];

   assign op_ready_o = !st_ff.busy;
   assign fire       = op_valid_i && op_ready_o;

   // Product shifter on every product read
   dmc_pshift u_pshift (
      .prod_i    (st_ff.prod_reg),
      .sel_i     (st_ff.ps_sel),
      .shifted_o (ps_out)
   ); // [RULE10]

   // Input shifter: zero fill low, sign or zero fill high
   assign ext_data = st_ff.sx_sel ?
                     {{16{data_read_bus_i[15]}}, data_read_bus_i} :
                     {16'h0, data_read_bus_i};                 // [RULE24]
   assign is_imm   = ext_data << shift_count_i;               // [RULE24]
   assign is_opnd  = ext_data << st_ff.opnd_reg[3:0];         // [RULE14]

   // Multiplier operand routing
   assign sq_sel = (op_code_i == OP_SQUARE_ADD) ||
                   (op_code_i == OP_SQUARE_SUB);
   assign ms_sel = (op_code_i == OP_MULT_SUM) ||
                   (op_code_i == OP_MULT_SUM_MOVE);
   assign mul_a  = (!st_ff.busy && (sq_sel || ms_sel)) ? data_read_bus_i
                                                       : st_ff.opnd_reg;
   always_comb begin
      if (st_ff.busy) begin
         mul_b = 16'($signed(st_ff.imm));
      end else if (ms_sel) begin
         mul_b = program_read_bus_i; // [RULE5]
      end else begin
         mul_b = data_read_bus_i;    // [RULE8]
      end
   end
   assign prod_s = $signed(mul_a) * $signed(mul_b);       // [RULE26]
   assign prod_u = {16'h0, mul_a} * {16'h0, mul_b};       // [RULE7]

   assign operand_indexed_test_sel = data_read_bus_i[st_ff.opnd_reg[3:0]];

   // Operation decode and next state
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.move = 1'b0;
      alu_k       = ALU_NONE;
      cy_k        = CY_KEEP;
      alu_b       = ps_out;                               // [RULE12]
      cin         = 1'b0;
      if (st_ff.busy) begin
         nxt_st.prod_reg = 32'(prod_s);                   // [RULE3] [RULE11]
         nxt_st.busy     = 1'b0;
      end else if (fire) begin
         case (op_code_i)
            OP_LDOP: begin
               nxt_st.opnd_reg = data_read_bus_i;
            end
            OP_LDOP_MOVE_P: begin
               nxt_st.opnd_reg = data_read_bus_i;
               alu_k = ALU_LOAD;                          // [RULE4]
            end
            OP_LDOP_ADD_P: begin
               nxt_st.opnd_reg = data_read_bus_i;
               alu_k = ALU_ADD;                           // [RULE4]
               cy_k  = CY_NORMAL;
            end
            OP_LDOP_ADD_P_SHIFT: begin
               nxt_st.opnd_reg = data_read_bus_i;
               nxt_st.move     = 1'b1;                    // [RULE4]
               alu_k = ALU_ADD;
               cy_k  = CY_NORMAL;
            end
            OP_LDOP_SUB_P: begin
               nxt_st.opnd_reg = data_read_bus_i;
               alu_k = ALU_SUB;                           // [RULE4]
               cin   = 1'b1;
               cy_k  = CY_NORMAL;
            end
            OP_MULTIPLY: begin
               nxt_st.prod_reg = 32'(prod_s);             // [RULE9]
            end
            OP_MULTIPLY_IMM: begin
               nxt_st.imm  = data_read_bus_i[IMM_BITS-1:0];
               nxt_st.busy = 1'b1;                        // [RULE3]
            end
            OP_MULTIPLY_UNS: begin
               nxt_st.prod_reg = prod_u;                  // [RULE7]
            end
            OP_MULT_SUM, OP_MULT_SUM_MOVE: begin
               nxt_st.opnd_reg = data_read_bus_i;
               nxt_st.prod_reg = 32'(prod_s);             // [RULE5]
               nxt_st.move = (op_code_i == OP_MULT_SUM_MOVE); // [RULE6]
               alu_k = ALU_ADD;
               cy_k  = CY_NORMAL;
            end
            OP_SQUARE_ADD, OP_SQUARE_SUB: begin
               nxt_st.opnd_reg = data_read_bus_i;
               nxt_st.prod_reg = 32'(prod_s);             // [RULE8]
               alu_k = (op_code_i == OP_SQUARE_ADD) ? ALU_ADD : ALU_SUB;
               cin   = (op_code_i == OP_SQUARE_SUB);
               cy_k  = CY_NORMAL;
            end
            OP_LOAD_PROD_HIGH: begin
               nxt_st.prod_reg[31:16] = data_read_bus_i;  // [RULE11]
            end
            OP_SET_PSHIFT: begin
               nxt_st.ps_sel = data_read_bus_i[1:0];      // [RULE23]
            end
            OP_LOAD_SUM: begin
               alu_k = ALU_LOAD;
               alu_b = is_imm;
            end
            OP_ADD_SUM: begin
               alu_k = ALU_ADD;
               alu_b = is_imm;
               cy_k  = (shift_count_i == HIGH_SHIFT) ? CY_SET_ONLY
                                                     : CY_NORMAL; // [RULE21]
            end
            OP_SUB_SUM: begin
               alu_k = ALU_SUB;
               alu_b = is_imm;
               cin   = 1'b1;
               cy_k  = (shift_count_i == HIGH_SHIFT) ? CY_CLR_ONLY
                                                     : CY_NORMAL; // [RULE21]
            end
            OP_ADD_CARRY: begin
               alu_k = ALU_ADD;
               alu_b = {16'h0, data_read_bus_i};
               cin   = st_ff.carry;                       // [RULE20]
               cy_k  = CY_NORMAL;
            end
            OP_SUB_BORROW: begin
               alu_k = ALU_SUB;
               alu_b = {16'h0, data_read_bus_i};
               cin   = st_ff.carry;                       // [RULE20]
               cy_k  = CY_NORMAL;
            end
            OP_LOAD_SHIFT_OPND: begin
               alu_k = ALU_LOAD;
               alu_b = is_opnd;                           // [RULE14]
            end
            OP_ADD_SHIFT_OPND: begin
               alu_k = ALU_ADD;
               alu_b = is_opnd;                           // [RULE14]
               cy_k  = CY_NORMAL;
            end
            OP_SUB_SHIFT_OPND: begin
               alu_k = ALU_SUB;
               alu_b = is_opnd;                           // [RULE14]
               cin   = 1'b1;
               cy_k  = CY_NORMAL;
            end
            OP_AND: begin
               alu_k = ALU_AND;
               alu_b = is_imm;
            end
            OP_OR: begin
               alu_k = ALU_OR;
               alu_b = is_imm;
            end
            OP_XOR: begin
               alu_k = ALU_XOR;
               alu_b = is_imm;
            end
            OP_LEFT_JUSTIFY: begin
               if (st_ff.sum_reg == 32'h0) begin
                  nxt_st.tc = 1'b1;
               end else if (st_ff.sum_reg[31] ^ st_ff.sum_reg[30]) begin
                  nxt_st.tc = 1'b1;
               end else begin
                  nxt_st.tc = 1'b0;
                  nxt_st.sum_reg = st_ff.sum_reg << 1;    // [RULE13]
               end
            end
            OP_BIT_TEST: begin
               nxt_st.tc = data_read_bus_i[shift_count_i[3:0]];
            end
            OP_OPND_BIT_TEST: begin
               nxt_st.tc = operand_indexed_test_sel;                      // [RULE15]
            end
            OP_SHIFT_LEFT: begin
               nxt_st.carry   = st_ff.sum_reg[31];        // [RULE19]
               nxt_st.sum_reg = st_ff.sum_reg << 1;
            end
            OP_SHIFT_RIGHT: begin
               nxt_st.carry   = st_ff.sum_reg[0];         // [RULE19]
               nxt_st.sum_reg = {st_ff.sx_sel & st_ff.sum_reg[31],
                                 st_ff.sum_reg[31:1]};
            end
            OP_ROTATE_LEFT: begin
               nxt_st.carry   = st_ff.sum_reg[31];        // [RULE19]
               nxt_st.sum_reg = {st_ff.sum_reg[30:0], st_ff.carry};
            end
            OP_ROTATE_RIGHT: begin
               nxt_st.carry   = st_ff.sum_reg[0];         // [RULE19]
               nxt_st.sum_reg = {st_ff.carry, st_ff.sum_reg[31:1]};
            end
            OP_STATUS_SET, OP_STATUS_CLEAR: begin
               case (status_sel_i)
                  STS_CARRY: nxt_st.carry = (op_code_i == OP_STATUS_SET);
                  STS_SIGN_EXT: nxt_st.sx_sel = (op_code_i == OP_STATUS_SET);
                  STS_SATURATE: nxt_st.sat_en = (op_code_i == OP_STATUS_SET);
                  default: nxt_st.tc = (op_code_i == OP_STATUS_SET);
               endcase                                    // [RULE22]
            end
            OP_STATUS_LOAD: begin
               nxt_st.ps_sel = data_read_bus_i[ST_PS_LSB +: 2];
               nxt_st.carry  = data_read_bus_i[ST_C_POS]; // [RULE22]
               nxt_st.sx_sel = data_read_bus_i[ST_SX_POS];
               nxt_st.tc     = data_read_bus_i[ST_TC_POS];
               nxt_st.wrap   = data_read_bus_i[ST_WR_POS]; // [RULE25]
               nxt_st.sat_en = data_read_bus_i[ST_SAT_POS];
            end
            OP_BRANCH_WRAP: begin
               nxt_st.wrap = 1'b0;                        // [RULE18] [RULE25]
            end
            default: begin
               nxt_st.move = 1'b0;
            end
         endcase
      end

      // Central ALU: sum register is always one operand
      b_eff   = (alu_k == ALU_SUB) ? ~alu_b : alu_b;
      sum33   = {1'b0, st_ff.sum_reg} + {1'b0, b_eff} + {32'h0, cin};
      wrapped = (st_ff.sum_reg[31] == b_eff[31]) &&
                (sum33[31] != st_ff.sum_reg[31]);
      arith   = sum33[31:0];                              // [RULE17]
      if (wrapped && st_ff.sat_en) begin
         arith = st_ff.sum_reg[31] ? SAT_NEG : SAT_POS;   // [RULE16]
      end
      case (alu_k)
         ALU_LOAD: nxt_st.sum_reg = alu_b;
         ALU_AND:  nxt_st.sum_reg = st_ff.sum_reg & alu_b; // [RULE17]
         ALU_OR:   nxt_st.sum_reg = st_ff.sum_reg | alu_b;
         ALU_XOR:  nxt_st.sum_reg = st_ff.sum_reg ^ alu_b;
         ALU_ADD, ALU_SUB: begin
            nxt_st.sum_reg = arith;                       // [RULE12]
            if (wrapped) begin
               nxt_st.wrap = 1'b1;                        // [RULE16] [RULE25]
            end
         end
         default: nxt_st.sum_reg = nxt_st.sum_reg;
      endcase
      case (cy_k)
         CY_NORMAL:   nxt_st.carry = sum33[32];           // [RULE19]
         CY_SET_ONLY: nxt_st.carry = st_ff.carry | sum33[32]; // [RULE21]
         CY_CLR_ONLY: nxt_st.carry = st_ff.carry & sum33[32]; // [RULE21]
         default:     nxt_st.carry = nxt_st.carry;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RST;                                 // [RULE22]
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sum_register_o           = st_ff.sum_reg;
   assign product_holding_reg_o    = st_ff.prod_reg;
   assign multiplier_operand_reg_o = st_ff.opnd_reg;
   assign product_shifter_o        = ps_out;              // [RULE10]
   assign product_shift_select_o   = st_ff.ps_sel;
   assign carry_o                  = st_ff.carry;         // [RULE22]
   assign arith_wrap_flag_o        = st_ff.wrap;          // [RULE18]
   assign saturation_enable_o      = st_ff.sat_en;
   assign sign_extend_select_o     = st_ff.sx_sel;
   assign test_flag_o              = st_ff.tc;
   assign zero_result_cond_o       = (st_ff.sum_reg == 32'h0); // [RULE18]
   assign computed_jump_o          = st_ff.sum_reg[15:0]; // [RULE18]
   assign data_move_o              = st_ff.move;          // [RULE6]

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   sequence s_imm_start;
      fire && (op_code_i == OP_MULTIPLY_IMM);
   endsequence
   sequence s_imm_finish;
      !op_ready_o ##1 op_ready_o;
   endsequence

   AST_PSHIFT_R6: assert property ( // [RULE1]
      product_shift_select_o == PS_R6 |->
      product_shifter_o == 32'($signed(product_holding_reg_o) >>> 6))
      else $error("right six product shift wrong");
   AST_MULT_SIGNED: assert property ( // [RULE26]
      fire && op_code_i == OP_MULTIPLY |=> product_holding_reg_o ==
      32'($signed($past(multiplier_operand_reg_o)) *
          $signed($past(data_read_bus_i))))
      else $error("signed product wrong or late");
   AST_MULT_UNS: assert property ( // [RULE7]
      fire && op_code_i == OP_MULTIPLY_UNS |=> product_holding_reg_o ==
      {16'h0, $past(multiplier_operand_reg_o)} *
      {16'h0, $past(data_read_bus_i)})
      else $error("unsigned product wrong");
   AST_SQUARE: assert property ( // [RULE8]
      fire && op_code_i == OP_SQUARE_ADD |=> product_holding_reg_o ==
      32'($signed($past(data_read_bus_i)) * $signed($past(data_read_bus_i))))
      else $error("square product wrong");
   AST_IMM_TWO_CYCLE: assert property ( // [RULE3]
      s_imm_start |=> s_imm_finish)
      else $error("immediate multiply not two cycles");
   AST_IMM_ZERO: assert property ( // [RULE11]
      s_imm_start and (data_read_bus_i[12:0] == 13'h0) |->
      ##2 product_holding_reg_o == 32'h0)
      else $error("times zero did not clear product");
   AST_SAT_POS: assert property ( // [RULE16]
      fire && op_code_i == OP_ADD_SUM && saturation_enable_o &&
      shift_count_i == 5'h0 && data_read_bus_i == 16'h0001 &&
      sum_register_o == 32'h7fff_ffff |=>
      sum_register_o == 32'h7fff_ffff && arith_wrap_flag_o)
      else $error("positive saturation wrong");
   AST_WRAP_STICKY: assert property ( // [RULE25]
      arith_wrap_flag_o && !(fire && (op_code_i == OP_BRANCH_WRAP ||
      op_code_i == OP_STATUS_LOAD)) |=> arith_wrap_flag_o)
      else $error("wrap flag dropped");
   AST_LOGIC_KEEP: assert property ( // [RULE17]
      fire && (op_code_i inside {OP_AND, OP_OR, OP_XOR, OP_LOAD_SUM}) |=>
      $stable(carry_o) && $stable(arith_wrap_flag_o))
      else $error("logic op touched carry or wrap");
   AST_OPERAND_INDEXED_TEST: assert property ( // [RULE15]
      fire && op_code_i == OP_OPND_BIT_TEST |=>
      $stable(sum_register_o) && test_flag_o == $past(operand_indexed_test_sel))
      else $error("operand bit test wrong");

endmodule : dmc_core

// ==== rtl/dmc_pkg.sv ====
// Constants and types shared by the multiplier and arithmetic datapath
package dmc_pkg;

   localparam int DATA_W = 16;
   localparam int SUM_W  = 32;

   // Product shift select encodings
   localparam logic [1:0] PS_NONE = 2'h0;
   localparam logic [1:0] PS_L1   = 2'h1;
   localparam logic [1:0] PS_L4   = 2'h2;
   localparam logic [1:0] PS_R6   = 2'h3;
   localparam int PS_L1_BITS = 1;
   localparam int PS_L4_BITS = 4;
   localparam int PS_R6_BITS = 6;

   // Short immediate width and the shift count that means high word
   localparam int         IMM_BITS   = 13;
   localparam logic [4:0] HIGH_SHIFT = 5'h10;

   // Saturation values
   localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
   localparam logic [31:0] SAT_NEG = 32'h8000_0000;

   // Field positions of the status word used by the status load
   localparam int ST_PS_LSB  = 0;
   localparam int ST_C_POS   = 9;
   localparam int ST_SX_POS  = 10;
   localparam int ST_TC_POS  = 11;
   localparam int ST_WR_POS  = 12;
   localparam int ST_SAT_POS = 13;

   // Reset values
   localparam logic       RST_CARRY = 1'b1;
   localparam logic       RST_SX    = 1'b1;
   localparam logic       RST_SAT   = 1'b0;
   localparam logic       RST_WRAP  = 1'b0;
   localparam logic [1:0] RST_PS    = PS_NONE;

   typedef enum logic [5:0] {
      OP_NOP, OP_LDOP, OP_LDOP_MOVE_P, OP_LDOP_ADD_P, OP_LDOP_ADD_P_SHIFT,
      OP_LDOP_SUB_P, OP_MULTIPLY, OP_MULTIPLY_IMM, OP_MULTIPLY_UNS,
      OP_MULT_SUM, OP_MULT_SUM_MOVE, OP_SQUARE_ADD, OP_SQUARE_SUB,
      OP_LOAD_PROD_HIGH, OP_SET_PSHIFT, OP_LOAD_SUM, OP_ADD_SUM,
      OP_SUB_SUM, OP_ADD_CARRY, OP_SUB_BORROW, OP_LOAD_SHIFT_OPND,
      OP_ADD_SHIFT_OPND, OP_SUB_SHIFT_OPND, OP_AND, OP_OR, OP_XOR,
      OP_LEFT_JUSTIFY, OP_BIT_TEST, OP_OPND_BIT_TEST, OP_SHIFT_LEFT,
      OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_STATUS_SET,
      OP_STATUS_CLEAR, OP_STATUS_LOAD, OP_BRANCH_WRAP
   } dmc_op_type;

   typedef enum logic [1:0] {
      STS_CARRY, STS_SIGN_EXT, STS_SATURATE, STS_TEST
   } dmc_sts_type;

   typedef enum logic [2:0] {
      ALU_NONE, ALU_LOAD, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
   } dmc_alu_type;

   typedef enum logic [1:0] {
      CY_KEEP, CY_NORMAL, CY_SET_ONLY, CY_CLR_ONLY
   } dmc_cy_type;

endpackage : dmc_pkg

// ==== rtl/dmc_pshift.sv ====
// Product shifter between the product register and the ALU or data bus
`timescale 1ns/1ps
module dmc_pshift (
   input  wire logic [31:0] prod_i,
   input  wire logic [1:0]  sel_i,
   output logic      [31:0] shifted_o
);
   import dmc_pkg::*;

   always_comb begin
      case (sel_i)
         PS_L1:   shifted_o = prod_i << PS_L1_BITS;   // [RULE1] [RULE23]
         PS_L4:   shifted_o = prod_i << PS_L4_BITS;   // [RULE2] [RULE23]
         PS_R6:   shifted_o = 32'($signed(prod_i) >>> PS_R6_BITS); // [RULE1]
         default: shifted_o = prod_i;
      endcase
   end

endmodule : dmc_pshift

// ==== sim/dmc_seq_model.sv ====
// Sequencer model that issues operations to the datapath
`timescale 1ns/1ps
module dmc_seq_model (
   input  wire logic            mclk_i,
   input  wire logic            op_ready_i,
   input  wire logic            data_move_i,
   output logic                 op_valid_o,
   output dmc_pkg::dmc_op_type  op_code_o,
   output logic [15:0]          data_o,
   output logic [15:0]          coef_o,
   output logic [4:0]           count_o,
   output dmc_pkg::dmc_sts_type sel_o,
   output int                   moves_o
);
   import dmc_pkg::*;
   initial begin
      op_valid_o = 1'b0;
      op_code_o = OP_NOP;
      data_o = 16'h0;
      coef_o = 16'h0;
      count_o = 5'h0;
      sel_o = STS_CARRY;
      moves_o = 0;
   end
   // Count sample moves requested by the datapath
   always @(posedge mclk_i) begin
      if (data_move_i === 1'b1) moves_o <= moves_o + 1;
   end
   // Hold the request until the edge that takes it
   task issue(input dmc_op_type c, input logic [15:0] d,
              input logic [15:0] k, input logic [4:0] s,
              input dmc_sts_type t, output bit ok);
      int n;
      op_valid_o <= 1'b1;
      op_code_o <= c;
      data_o <= d;
      coef_o <= k;
      count_o <= s;
      sel_o <= t;
      n = 0;
      @(negedge mclk_i);
      while (op_ready_i !== 1'b1 && n < 20) begin
         n++;
         @(negedge mclk_i);
      end
      ok = (n < 20);
      @(posedge mclk_i);
   endtask : issue
   task idle();
      op_valid_o <= 1'b0;
   endtask : idle
endmodule : dmc_seq_model

// ==== sim/tb.sv ====
// Self-checking bench for the arithmetic datapath
`timescale 1ns/1ps
module tb;
   import dmc_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        vld, rdy, dmv, cy, wr, zr, tf;
   dmc_op_type  opc;
   dmc_sts_type sel, tsel;
   logic [15:0] dat, coef, jmp, opr;
   logic [4:0]  cnt;
   logic [31:0] sum, prod, psh;
   logic [31:0] seed = 32'h60919cf5;
   logic [31:0] a, b;
   int          error_cnt = 0;
   int          checks = 0;
   int          moves, m0;
   bit          ok;
   initial forever #5 mclk_i = ~mclk_i;
   dmc_seq_model seq (.mclk_i, .op_ready_i(rdy), .data_move_i(dmv),
      .op_valid_o(vld), .op_code_o(opc), .data_o(dat), .coef_o(coef),
      .count_o(cnt), .sel_o(sel), .moves_o(moves));
   dmc_core dut (.mclk_i, .rst_n_i, .op_valid_i(vld), .op_code_i(opc),
      .data_read_bus_i(dat), .program_read_bus_i(coef),
      .shift_count_i(cnt), .status_sel_i(sel), .op_ready_o(rdy),
      .sum_register_o(sum), .product_holding_reg_o(prod),
      .multiplier_operand_reg_o(opr), .product_shifter_o(psh),
      .product_shift_select_o(), .carry_o(cy), .arith_wrap_flag_o(wr),
      .saturation_enable_o(), .sign_extend_select_o(), .test_flag_o(tf),
      .zero_result_cond_o(zr), .computed_jump_o(jmp),
      .data_move_o(dmv));
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function logic [31:0] pshift(input logic [31:0] p, input logic [1:0] m);
      case (m)
         2'h0: return p;
         2'h1: return p << 1;
         2'h2: return p << 4;
         default: return $unsigned($signed(p) >>> 6);
      endcase
   endfunction : pshift
   task complete_run();
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   task cmp(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
   endtask : cmp
   task run(input dmc_op_type c, input logic [15:0] d, input logic [4:0] s);
      @(posedge mclk_i);
      seq.issue(c, d, 16'h0, s, tsel, ok);
      seq.idle();
      if (!ok) begin
         error_cnt++;
         complete_run();
      end
      @(negedge mclk_i);
   endtask : run
   initial begin
      tsel = STS_CARRY;
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(negedge mclk_i);
      cmp(cy, 1'b1);
      cmp(wr, 1'b0);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         a = seed;
         seed = lfsr(seed);
         b = seed;
         run(OP_LDOP, a[15:0], 5'h0);
         run(OP_MULTIPLY, b[15:0], 5'h0);
         cmp(prod, $signed(a[15:0]) * $signed(b[15:0]));
         run(OP_MULTIPLY_UNS, b[15:0], 5'h0);
         cmp(prod, a[15:0] * b[15:0]);
         run(OP_SQUARE_ADD, b[15:0], 5'h0);
         cmp(prod, $signed(b[15:0]) * $signed(b[15:0]));
         for (int m = 0; m < 4; m++) begin
            run(OP_SET_PSHIFT, m[15:0], 5'h0);
            cmp(psh, pshift(prod, m[1:0]));
         end
      end
      run(OP_LDOP, 16'h8001, 5'h0);
      run(OP_MULTIPLY_IMM, 16'h0000, 5'h0);
      cmp(rdy, 1'b0);
      @(negedge mclk_i);
      cmp(prod, 32'h0);
      run(OP_MULTIPLY_IMM, 16'h1fff, 5'h0);
      @(negedge mclk_i);
      cmp(prod, 32'h00007fff);
      run(OP_MULTIPLY_IMM, 16'h0001, 5'h0);
      @(negedge mclk_i);
      run(OP_LOAD_PROD_HIGH, 16'h1234, 5'h0);
      cmp(prod, 32'h12348001);
      run(OP_STATUS_SET, 16'h0, 5'h0);
      tsel = STS_SATURATE;
      run(OP_STATUS_SET, 16'h0, 5'h0);
      run(OP_LOAD_SUM, 16'h7fff, 5'h10);
      cmp(sum, 32'h7fff0000);
      run(OP_ADD_SUM, 16'h7fff, 5'h10);
      cmp(sum, SAT_POS);
      cmp({wr, cy}, 2'h3);
      run(OP_ADD_SUM, 16'h0001, 5'h0);
      cmp(sum, SAT_POS);
      run(OP_LOAD_SUM, 16'h8000, 5'h10);
      run(OP_SUB_SUM, 16'h0001, 5'h10);
      cmp(sum, SAT_NEG);
      run(OP_BRANCH_WRAP, 16'h0, 5'h0);
      cmp(wr, 1'b0);
      run(OP_STATUS_CLEAR, 16'h0, 5'h0);
      run(OP_LOAD_SUM, 16'h7fff, 5'h10);
      run(OP_ADD_SUM, 16'h7fff, 5'h10);
      cmp(wr, 1'b1);
      cmp(sum, 32'hfffe0000);
      run(OP_LOAD_SUM, 16'h0, 5'h0);
      cmp(zr, 1'b1);
      tsel = STS_CARRY;
      run(OP_STATUS_SET, 16'h0, 5'h0);
      run(OP_LOAD_SUM, 16'h1234, 5'h0);
      cmp({zr, jmp}, {1'b0, 16'h1234});
      run(OP_ADD_CARRY, 16'h0001, 5'h0);
      cmp(sum, 32'h1236);
      run(OP_SET_PSHIFT, 16'h0, 5'h0);
      run(OP_LDOP, 16'h0003, 5'h0);
      run(OP_MULTIPLY, 16'h0002, 5'h0);
      run(OP_LOAD_SUM, 16'h0005, 5'h0);
      run(OP_LDOP_SUB_P, 16'h0004, 5'h0);
      cmp(sum, 32'hffffffff);
      cmp({opr, 15'h0, cy}, 32'h00040000);
      run(OP_LDOP_ADD_P, 16'h0005, 5'h0);
      cmp({opr, 15'h0, cy}, 32'h00050001);
      run(OP_LDOP_MOVE_P, 16'h0005, 5'h0);
      cmp(sum, 32'h6);
      run(OP_ADD_SHIFT_OPND, 16'h0001, 5'h0);
      cmp(sum, 32'h26);
      run(OP_OPND_BIT_TEST, 16'h0020, 5'h0);
      cmp({tf, sum[30:0]}, 32'h80000026);
      run(OP_LEFT_JUSTIFY, 16'h0, 5'h0);
      cmp({tf, sum[30:0]}, 32'h0000004c);
      run(OP_SUB_BORROW, 16'h0001, 5'h0);
      cmp({cy, sum[30:0]}, 32'h8000004a);
      run(OP_SHIFT_RIGHT, 16'h0, 5'h0);
      cmp({cy, sum[30:0]}, 32'h00000025);
      m0 = moves;
      @(posedge mclk_i);
      seq.issue(OP_MULT_SUM_MOVE, a[15:0], b[15:0], 5'h0, tsel, ok);
      cmp(ok, 1'b1);
      seq.issue(OP_MULT_SUM_MOVE, b[15:0], a[15:0], 5'h0, tsel, ok);
      cmp(ok, 1'b1);
      seq.idle();
      repeat (3) @(negedge mclk_i);
      cmp(moves - m0, 2);
      cmp(prod, $signed(a[15:0]) * $signed(b[15:0]));
      complete_run();
   end
endmodule : tb
